// ===== pot_cmd_unit.sv
// serial command unit of a single 256-tap digital potentiometer
`timescale 1ns/100ps
// Functional notes
// R1 - write-lock low blocks every nonvolatile setting write.
// R2 - serial input bits are sampled on rising serial clock.
// R3 - host keeps select low, pause and lock high during operation.
// R4 - serial output floats whenever not transmitting.
// R5 - wiper position decodes to one-hot select of 256 taps.
// R6 - wiper changes only by write, transfer, step or power-up reload.
// R7 - power-up loads wiper from bank zero register zero.
// R8 - nonvolatile write completes within 10 ms.
// R9 - status bit is 1 during nonvolatile write, else 0.
// R10 - first byte is identification; upper nibble device type checked.
// R11 - both address bits must match straps, else sequence ignored.
// R12 - instruction byte: opcode nibble, register select, bank select.
// R13 - sixteen registers in four banks; only bank zero transfers.
// R14 - bank and register selects encode 0..3 in binary.
// R15 - five commands carry a third data byte.
// R16 - two transfer commands are two bytes, no data.
// R17 - setting-to-wiper loads after settle; reverse starts nv write.
// R18 - step command: each clock moves wiper up if input high, else down.
// R19 - nv save starts only at select rise after complete write.
// R20 - read data shifts out on falling serial clock.
// R21 - pause input low freezes sequence; state kept.
// R22 - no operation until select has fallen after power-up.
// R23 - stepping saturates at 255 and 0.
// R24 - incomplete or locked write starts no nv cycle.
// R25 - mismatched identity keeps output floating until next select fall.
module pot_cmd_unit
  import pot_cmd_pkg::*;
#(
  parameter int NV_CYCLES = pot_cmd_pkg::NV_WRITE_CYC
) (
  // system
  input  wire logic         clk_sys_i,
  input  wire logic         srst_i,
  // serial link
  input  wire logic         sck_i,
  input  wire logic         cs_n_i,
  input  wire logic         sdi_i,
  input  wire logic         hold_n_i,
  output logic              sdo_o,
  output logic              sdo_oe_o,
  // straps and lock
  input  wire logic [1:0]   addr_strap_i,
  input  wire logic         wr_lock_n_i,
  // potentiometer
  output logic [255:0]      tap_sel_o,
  output logic [7:0]        wiper_position_o,
  output logic              nv_write_active_o
);
  import pot_cmd_pkg::*;

  // ---------------------------------------------------------------
  // link domain: shifter on serial clock
  // ---------------------------------------------------------------
  // wiper/status snapshot crosses slowly; only read while no step runs
  logic [1:0] strap_s1, strap_s2;
  logic [7:0] wiper_l1, wiper_l2;
  logic       wip_l1, wip_l2, lock_l1, lock_l2;

  logic [2:0]  bit_cnt;
  logic [1:0]  byte_cnt;
  logic [7:0]  shreg;
  logic [3:0]  op;
  logic [3:0]  idx;
  logic        bad;
  logic        stepping;
  logic        rd_act;
  logic [7:0]  tx;
  link_cmd_t   cmd;
  link_cmd_t   cmd_nxt;
  logic        cmd_tgl;
  logic        cmd_fire;
  step_evt_t   step;
  logic        step_fire;
  logic [7:0]  rd_set_data;

  always_ff @(posedge sck_i) begin
    strap_s1 <= addr_strap_i;
    strap_s2 <= strap_s1;
    wiper_l1 <= wiper_position_o;
    wiper_l2 <= wiper_l1;
    wip_l1   <= nv_write_active_o;
    wip_l2   <= wip_l1;
    lock_l1  <= wr_lock_n_i;
    lock_l2  <= lock_l1;
  end

  // select high clears the frame asynchronously: the link clock stops outside frames
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= BYTE_ID;
      bad      <= 1'b0;
      stepping <= 1'b0;
      shreg    <= 8'h00;
      op       <= 4'h0;
      idx      <= 4'h0;
    end else if (hold_n_i) begin  // R21
      if (!stepping && !bad && byte_cnt != BYTE_DONE) begin
        shreg   <= {shreg[6:0], sdi_i};  // R2
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == LAST_BIT) begin
          byte_cnt <= byte_cnt + 2'h1;
          case (byte_cnt)
            BYTE_ID: begin
              if (shreg[6:3] != DEVICE_TYPE || shreg[2:1] != ADDR_HI_ZERO ||
                  {shreg[0], sdi_i} != strap_s2)  // R10 R11
                bad <= 1'b1;
            end
            BYTE_INSTR: begin
              op  <= shreg[6:3];  // R12
              idx <= {shreg[0], sdi_i, shreg[2:1]};  // R14: bank then register
              if (shreg[6:3] == OP_STEP)
                stepping <= 1'b1;
              if (shreg[6:3] == OP_SET2WIP || shreg[6:3] == OP_WIP2SET)
                byte_cnt <= BYTE_DONE;  // R16
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // link to system handover
  // ---------------------------------------------------------------
  // a toggle plus held payload; the payload is stable long before
  // the toggle has passed the system-side synchroniser
  always_comb begin
    cmd_fire  = 1'b0;
    step_fire = 1'b0;
    cmd_nxt   = cmd;
    if (!cs_n_i && hold_n_i) begin
      if (stepping) begin
        step_fire = 1'b1;  // R18
      end else if (!bad && bit_cnt == LAST_BIT) begin
        if (byte_cnt == BYTE_INSTR &&
            (shreg[6:3] == OP_SET2WIP || shreg[6:3] == OP_WIP2SET)) begin  // R16
          cmd_fire      = 1'b1;
          cmd_nxt.op    = shreg[6:3];
          cmd_nxt.index = {BANK_ZERO, shreg[2:1]};  // R13
          cmd_nxt.data  = 8'h00;
        end
        if (byte_cnt == BYTE_DATA && (op == OP_WR_WIPER || op == OP_WR_SET)) begin  // R15
          cmd_fire      = 1'b1;
          cmd_nxt.op    = op;
          cmd_nxt.index = idx;
          cmd_nxt.data  = {shreg[6:0], sdi_i};
        end
      end
    end
  end

  // toggles see only the system reset, so a frame cut by select keeps them
  always_ff @(posedge sck_i or posedge srst_i) begin
    if (srst_i) begin
      cmd_tgl <= 1'b0;
      cmd     <= '0;
      step    <= '0;
    end else begin
      if (cmd_fire) begin
        cmd_tgl <= ~cmd_tgl;
        cmd     <= cmd_nxt;
      end
      if (step_fire) begin
        step.tgl <= ~step.tgl;
        step.up  <= sdi_i;
      end
    end
  end

  // read data is set up on the falling edge after the instruction byte
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rd_act <= 1'b0;
      tx     <= 8'h00;
    end else if (hold_n_i) begin
      if (!bad && byte_cnt == BYTE_DATA && bit_cnt == 3'h0 && !rd_act) begin
        rd_act <= (op == OP_RD_WIPER) || (op == OP_RD_SET) || (op == OP_STATUS);
        case (op)
          OP_RD_WIPER: tx <= wiper_l2;
          OP_RD_SET:   tx <= rd_set_data;
          OP_STATUS:   tx <= {7'h00, wip_l2};  // R9
          default:     tx <= 8'h00;
        endcase
      end else if (rd_act)
        tx <= {tx[6:0], 1'b0};  // R20
      if (byte_cnt == BYTE_DONE)
        rd_act <= 1'b0;
    end
  end

  assign sdo_o    = tx[7];
  assign sdo_oe_o = rd_act && !cs_n_i && hold_n_i && !bad;  // R4 R22 R25

  // setting array is written by the system side only after a save cycle;
  // a read racing a save of the same register may return the old value
  logic [7:0] nv_mem [16];
  assign rd_set_data = nv_mem[idx];

  // ---------------------------------------------------------------
  // system domain
  // ---------------------------------------------------------------
  typedef enum logic [1:0] { ST_BOOT, ST_IDLE, ST_SETTLE, ST_NVWR } st_t;

  typedef struct packed {
    st_t        st;
    logic [7:0] wiper;
    logic       nv_write_active;
    logic [23:0] cnt;
    logic [2:0] cmd_s;
    logic [2:0] step_s;
    logic [3:0] cs_s;
    logic [1:0] lock_s;
    logic       armed;
    logic       pend;
    logic [3:0] pidx;
    logic [7:0] pdata;
    logic       commit;
    logic [7:0] ld_val;
  } core_t;

  core_t r, next_r;
  link_cmd_t cmd_q;
  logic      step_up_q;
  logic      cs_rise;
  logic      cs_fall;

  // select edges are taken one stage late so that a command toggle sent
  // just before select rises is always seen first
  assign cs_rise = r.cs_s[2] && !r.cs_s[3];
  assign cs_fall = !r.cs_s[2] && r.cs_s[3];

  always_comb begin
    next_r        = r;
    next_r.commit = 1'b0;
    next_r.cmd_s  = {r.cmd_s[1:0], cmd_tgl};
    next_r.step_s = {r.step_s[1:0], step.tgl};
    next_r.cs_s   = {r.cs_s[2:0], cs_n_i};
    next_r.lock_s = {r.lock_s[0], wr_lock_n_i};
    if (cs_fall) next_r.armed = 1'b1;  // R22
    case (r.st)
      ST_BOOT: begin
        next_r.wiper = nv_mem[DEFAULT_IX];  // R7
        next_r.st    = ST_IDLE;
      end
      ST_IDLE, ST_SETTLE: begin
        if (r.st == ST_SETTLE) begin
          if (r.cnt == 24'(SETTLE_CYC - 1)) begin
            next_r.wiper = r.ld_val;  // R17
            next_r.st    = ST_IDLE;
          end else
            next_r.cnt = r.cnt + 24'h1;
        end
        if (r.armed && r.cmd_s[2] != r.cmd_s[1]) begin
          case (cmd_q.op)
            OP_WR_WIPER: next_r.wiper = cmd_q.data;  // R6
            OP_SET2WIP: begin
              next_r.ld_val = nv_mem[cmd_q.index];
              next_r.cnt    = 24'h0;
              next_r.st     = ST_SETTLE;
            end
            OP_WR_SET: begin
              next_r.pend  = 1'b1;
              next_r.pidx  = cmd_q.index;
              next_r.pdata = cmd_q.data;
            end
            OP_WIP2SET: begin
              next_r.pend  = 1'b1;
              next_r.pidx  = cmd_q.index;
              next_r.pdata = r.wiper;
            end
            default: ;
          endcase
        end
        if (r.armed && r.step_s[2] != r.step_s[1]) begin
          if (step_up_q && r.wiper != WIPER_MAX) next_r.wiper = r.wiper + 8'h1;  // R18 R23
          else if (!step_up_q && r.wiper != WIPER_MIN) next_r.wiper = r.wiper - 8'h1;
        end
        // save starts only on the select rise that closes a full write
        if (r.pend && cs_rise) begin  // R19
          next_r.pend = 1'b0;
          if (r.lock_s[1] && r.st == ST_IDLE) begin  // R1 R24
            next_r.nv_write_active = 1'b1;
            next_r.cnt = 24'h0;
            next_r.st  = ST_NVWR;
          end
        end
        if (cs_fall) next_r.pend = 1'b0;
      end
      ST_NVWR: begin
        if (r.cnt == 24'(NV_CYCLES - 1)) begin  // R8
          next_r.commit = 1'b1;
          next_r.nv_write_active    = 1'b0;
          next_r.st     = ST_IDLE;
        end else
          next_r.cnt = r.cnt + 24'h1;
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r.st     <= ST_BOOT;
      r.wiper  <= WIPER_MIN;
      r.nv_write_active    <= 1'b0;
      r.cnt    <= 24'h0;
      r.cmd_s  <= 3'h0;
      r.step_s <= 3'h0;
      r.cs_s   <= 4'hF;  // idle level, no false select edge after reset
      r.lock_s <= 2'h0;
      r.armed  <= 1'b0;
      r.pend   <= 1'b0;
      r.pidx   <= 4'h0;
      r.pdata  <= 8'h00;
      r.commit <= 1'b0;
      r.ld_val <= 8'h00;
    end else begin
      r <= next_r;
    end
    cmd_q     <= cmd;
    step_up_q <= step.up;
  end

  // array written in the system domain only after the save cycle completes
  always_ff @(posedge clk_sys_i) begin
    if (r.commit)
      nv_mem[r.pidx] <= r.pdata;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 256; g++) begin : g_tap
      assign tap_sel_o[g] = (r.wiper == 8'(g));  // R5
    end
  endgenerate

  assign wiper_position_o  = r.wiper;
  assign nv_write_active_o = r.nv_write_active;  // R9

endmodule : pot_cmd_unit

// ===== pot_cmd_pkg.sv
// shared constants and types for the serial potentiometer command unit
package pot_cmd_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int          BYTE_W       = 8;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [3:0]  DEVICE_TYPE  = 4'hA;  // arbitrary neutral code
  localparam logic [1:0]  ADDR_HI_ZERO = 2'h0;
  localparam logic [1:0]  BYTE_ID      = 2'h0;
  localparam logic [1:0]  BYTE_INSTR   = 2'h1;
  localparam logic [1:0]  BYTE_DATA    = 2'h2;
  localparam logic [1:0]  BYTE_DONE    = 2'h3;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SET   = 4'hB;
  localparam logic [3:0] OP_WR_SET   = 4'hC;
  localparam logic [3:0] OP_SET2WIP  = 4'hD;
  localparam logic [3:0] OP_WIP2SET  = 4'hE;
  localparam logic [3:0] OP_STEP     = 4'h2;
  localparam logic [3:0] OP_STATUS   = 4'h5;

  localparam logic [1:0] BANK_ZERO  = 2'h0;
  localparam logic [7:0] WIPER_MAX  = 8'hFF;
  localparam logic [7:0] WIPER_MIN  = 8'h00;
  localparam logic [3:0] DEFAULT_IX = 4'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ         = 20_000_000;
  localparam int NV_WRITE_MS    = 10;
  localparam int NV_WRITE_CYC   = CLK_HZ / 1000 * NV_WRITE_MS;
  localparam int SETTLE_NS      = 100;
  localparam int SETTLE_CYC_RAW = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;

  // event from the link domain, carried by a toggle plus held payload
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] index;
    logic [7:0] data;
  } link_cmd_t;

  typedef struct packed {
    logic       tgl;
    logic       up;
  } step_evt_t;

endpackage : pot_cmd_pkg

// ===== pot_cmd_unit_properties.sv
// port assertions for the potentiometer command unit
`timescale 1ns/100ps
module pot_cmd_unit_properties #(
  parameter int NV_CYCLES = 50
) (
  // clock and reset
  input wire logic         clk_sys_i,
  input wire logic         srst_i,
  // watched pins
  input wire logic         sck_i,
  input wire logic         cs_n_i,
  input wire logic         sdi_i,
  input wire logic         hold_n_i,
  input wire logic         sdo_o,
  input wire logic         sdo_oe_o,
  input wire logic [1:0]   addr_strap_i,
  input wire logic         wr_lock_n_i,
  input wire logic [255:0] tap_sel_o,
  input wire logic [7:0]   wiper_position_o,
  input wire logic         nv_write_active_o
);
  localparam int NV_MAX = NV_CYCLES + 8;
  logic [7:0] idle_cnt;
  logic       stored = 1'b0;
  logic       armed  = 1'b0;
  int         nv_run;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !nv_write_active_o) begin
      nv_run <= 0;
    end else begin
      nv_run <= nv_run + 1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      idle_cnt <= 8'hFF;
    end else if (!cs_n_i) begin
      idle_cnt <= 8'h00;
    end else if (idle_cnt != 8'hFF) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
    // tap check waits for a reset that follows a completed nv write to any register
    if ($fell(nv_write_active_o)) begin
      stored <= 1'b1;
    end
    if (srst_i && stored) begin
      armed <= 1'b1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  tap_onehot_a: assert property (armed && !$past(srst_i) |->
    tap_sel_o == (256'h1 << wiper_position_o)) else $error("tap select wrong");
  oe_idle_a: assert property (cs_n_i |-> !sdo_oe_o)
    else $error("serial out driven while deselected");
  nv_lock_a: assert property ($rose(nv_write_active_o) |-> wr_lock_n_i)
    else $error("nv write started while locked");
  nv_start_a: assert property ($rose(nv_write_active_o) |-> cs_n_i && idle_cnt < 8'h0A)
    else $error("nv write not started by select rise");
  nv_hold_a: assert property ($rose(nv_write_active_o) |-> nv_write_active_o [*8])
    else $error("nv flag dropped early");
  nv_len_a: assert property (nv_run <= NV_MAX)
    else $error("nv write too long");
  wiper_cause_a: assert property ($changed(wiper_position_o) && !$past(srst_i) &&
    !$past(srst_i, 2) |->
    idle_cnt < 8'h0C) else $error("wiper changed without a command");
  step_sat_a: assert property ($changed(wiper_position_o) && !$past(srst_i) |->
    {$past(wiper_position_o), wiper_position_o} != 16'hFF00
    && {$past(wiper_position_o), wiper_position_o} != 16'h00FF) else $error("wiper wrapped");
endmodule : pot_cmd_unit_properties

bind pot_cmd_unit pot_cmd_unit_properties #(.NV_CYCLES(NV_CYCLES)) pot_cmd_unit_properties_i (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .sdi_i(sdi_i),
  .hold_n_i(hold_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .addr_strap_i(addr_strap_i),
  .wr_lock_n_i(wr_lock_n_i), .tap_sel_o(tap_sel_o), .wiper_position_o(wiper_position_o),
  .nv_write_active_o(nv_write_active_o));

// ===== pot_spi_host.sv
// serial host model for the command unit's link pins
`timescale 1ns/100ps
module pot_spi_host (
  // link
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  output logic      hold_n_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    hold_n_o = 1'b1;
  end
  // msb first, then step pulses; a floating output reads as toggling bits
  task automatic frame(input logic [23:0] bits, input int nbit, input int nstep,
                       input logic up, input bit pause, output logic [7:0] rd);
    rd = 8'h00;
    cs_n_o = 1'b0;
    #150;
    for (int i = 0; i < nbit; i++) begin
      sdi_o = bits[23-i];
      if (pause && i == 12) begin
        hold_n_o = 1'b0;
        sdi_o = ~sdi_o;
        #3 sck_o = 1'b1;
        #3 sck_o = 1'b0;
        sdi_o = ~sdi_o;
        #100 hold_n_o = 1'b1;
      end
      #3 sck_o = 1'b1;
      rd = {rd[6:0], sdo_oe_i ? sdo_i : ~rd[0]};
      #3 sck_o = 1'b0;
    end
    for (int i = 0; i < nstep; i++) begin
      sdi_o = up;
      #3 sck_o = 1'b1;
      #3 sck_o = 1'b0;
      #200;
    end
    #3 cs_n_o = 1'b1;
    #400;
  endtask : frame
endmodule : pot_spi_host

// ===== spi_digital_pot_command_unit_tb_top.sv
// self-checking bench for the potentiometer command unit
`timescale 1ns/100ps
module spi_digital_pot_command_unit_tb_top;
  import pot_cmd_pkg::*;
  localparam int NV_CYC = 50;
  logic         clk_sys = 1'b0;
  logic         srst    = 1'b1;
  logic         lock_n  = 1'b1;
  logic [1:0]   strap   = 2'h2;
  logic         sck, cs_n, sdi, hold_n, sdo, sdo_oe, nv;
  logic [255:0] tap_sel;
  logic [7:0]   wiper;
  logic [7:0]   rd;
  int           miscompares = 0;
  int           check_count = 0;
  int           cycles      = 0;

  always #25 clk_sys = ~clk_sys;

  pot_cmd_unit #(.NV_CYCLES(NV_CYC)) pot_cmd_unit_i (
    .clk_sys_i(clk_sys), .srst_i(srst), .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi),
    .hold_n_i(hold_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .addr_strap_i(strap),
    .wr_lock_n_i(lock_n), .tap_sel_o(tap_sel), .wiper_position_o(wiper),
    .nv_write_active_o(nv));
  pot_spi_host pot_spi_host_i (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .hold_n_o(hold_n),
    .sdo_i(sdo), .sdo_oe_i(sdo_oe));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic send(input logic [3:0] typ, input logic [1:0] adr, input logic [3:0] op,
                      input logic [3:0] ix, input logic [7:0] d, input int nbit, input bit p);
    pot_spi_host_i.frame({typ, ADDR_HI_ZERO, adr, op, ix, d}, nbit, 0, 1'b0, p, rd);
  endtask : send
  task automatic cmd(input logic [3:0] op, input logic [3:0] ix, input logic [7:0] d,
                     input int nbit);
    send(DEVICE_TYPE, strap, op, ix, d, nbit, 1'b0);
  endtask : cmd
  task automatic steps(input logic up, input int n);
    pot_spi_host_i.frame({DEVICE_TYPE, ADDR_HI_ZERO, strap, OP_STEP, 12'h000}, 16, n, up,
                         1'b0, rd);
  endtask : steps
  task automatic wait_nv;
    for (int i = 0; i < NV_CYC + 20 && nv; i++) @(negedge clk_sys);
  endtask : wait_nv
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // whole run needs about five hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end

  // ----
  // tests
  // ----
  initial begin
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    cmd(OP_WR_SET, 4'h0, 8'h3C, 24);
    check("nv busy", 8'h01, {7'h00, nv});
    cmd(OP_STATUS, 4'h1, 8'h00, 24);
    check("status busy", 8'h01, rd);
    wait_nv();
    cmd(OP_STATUS, 4'h1, 8'h00, 24);
    check("status idle", 8'h00, rd);
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("reload", 8'h3C, wiper);
    $display("test reload done");
    cmd(OP_WR_WIPER, 4'h0, 8'hFE, 24);
    cmd(OP_RD_WIPER, 4'h0, 8'h00, 24);
    check("read wiper", 8'hFE, rd);
    steps(1'b1, 3);
    check("step up", 8'hFF, wiper);
    steps(1'b0, 2);
    check("step down", 8'hFD, wiper);
    cmd(OP_WR_WIPER, 4'h0, 8'h00, 24);
    steps(1'b0, 1);
    check("floor", 8'h00, wiper);
    $display("test wiper done");
    cmd(OP_WR_SET, 4'h9, 8'hA5, 24);
    wait_nv();
    @(negedge clk_sys);
    lock_n = 1'b0;
    cmd(OP_WR_SET, 4'h9, 8'h11, 24);
    check("locked busy", 8'h00, {7'h00, nv});
    @(negedge clk_sys);
    lock_n = 1'b1;
    cmd(OP_WR_SET, 4'h9, 8'h22, 20);
    check("short busy", 8'h00, {7'h00, nv});
    cmd(OP_RD_SET, 4'h9, 8'h00, 24);
    check("bank one", 8'hA5, rd);
    $display("test settings done");
    cmd(OP_WR_WIPER, 4'h0, 8'h77, 24);
    cmd(OP_WIP2SET, 4'h4, 8'h00, 16);
    check("save busy", 8'h01, {7'h00, nv});
    wait_nv();
    cmd(OP_WR_WIPER, 4'h0, 8'h10, 24);
    cmd(OP_SET2WIP, 4'h4, 8'h00, 16);
    check("recall", 8'h77, wiper);
    $display("test transfer done");
    send(DEVICE_TYPE, ~strap, OP_WR_WIPER, 4'h0, 8'h55, 24, 1'b0);
    check("strap miss", 8'h77, wiper);
    send(~DEVICE_TYPE, strap, OP_RD_WIPER, 4'h0, 8'h00, 24, 1'b0);
    check("type miss", 8'hAA, rd);
    send(DEVICE_TYPE, strap, OP_WR_WIPER, 4'h0, 8'h42, 24, 1'b1);
    check("paused write", 8'h42, wiper);
    $display("test identity done");
    close_out();
  end
endmodule : spi_digital_pot_command_unit_tb_top
